// ==== i2sb_pkg.sv ====
// Purpose: Shared constants and types of the two-wire to SPI bridge
// Assumes: One system clock, byte-wide buffer of 128 entries
// Notes:   Command codes, config fields and counter limits of the bridge are named here once
package i2sb_pkg;
  localparam logic [7:0] CMD_CONFIG     = 8'h01;
  localparam logic [7:0] CMD_WRITE      = 8'h02;
  localparam logic [7:0] CMD_CLRIRQ     = 8'h03;
  localparam logic [7:0] CFG_RESET      = 8'hf8;
  localparam int         CFG_SEL_MSB    = 7;
  localparam int         CFG_SEL_LSB    = 3;
  localparam int         CFG_ORDER_BIT  = 2;
  localparam int         CFG_CPHA_BIT   = 1;
  localparam int         CFG_CPOL_BIT   = 0;
  localparam int         BUF_DEPTH      = 128;
  localparam int         BUF_AW         = 7;
  localparam logic [7:0] BUF_FULL_CNT   = 8'h80;
  localparam logic [3:0] LAST_RX_BIT    = 4'h7;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [3:0] LAST_EDGE      = 4'hf;
  localparam logic [4:0] SEL_IDLE       = 5'h1f;
  localparam logic [1:0] FIFO_DEPTH     = 2'h2;

  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_RX, I2C_ACK_WAIT, I2C_ACK, I2C_TX, I2C_MACK, I2C_TX_LOAD
  } i2sb_i2c_state_type;

  typedef enum logic [1:0] {SPI_IDLE, SPI_LOAD, SPI_SHIFT} i2sb_spi_state_type;
endpackage : i2sb_pkg

// ==== i2sb_bridge.sv ====
// Purpose: Two-wire serial slave that drives an SPI master with a byte buffer
// Assumes: 100 MHz clk; bus pins are asynchronous and pass two flip-flops
// Notes:   Open-drain data is split into input, output and output enable
// How it works
// - Address byte upper seven bits compared with fixed build parameter.
// - Low last address bit starts a write toward the bridge.
// - High last address bit starts a read; bridge drives data out.
// - Codes: 0x01 configure, 0x02 load data, 0x03 clear interrupt.
// - Byte after configure command becomes the SPI configuration byte.
// - Config: selects bits 7..3, order bit 2, CPHA 1, CPOL 0; reset 0xf8.
// - Each select bit drives its matching active-low select output.
// - All four SPI modes via CPOL idle level and CPHA edge choice.
// - Order bit zero shifts MSB first, otherwise LSB first.
// - Any combination of select outputs may be active together.
// - After load command, accept one up to 128 payload bytes.
// - Active-low interrupt goes low when the SPI transfer finishes.
// - All state except the buffer and prefetch buffer contents resets asynchronously and stays in reset until two clocks after reset input falls.
// - On stop after load, shift received count from index zero, overwrite.
// - No bus acknowledge during SPI transfer; interrupt and resume after.
// - Reads return buffer from index zero, wrapping after 128, unmodified.
// - SPI clock toggles only in transfers at clk over 2*(divider+1).
`timescale 1ns/100ps
module i2sb_bridge
  import i2sb_pkg::*;
#(
  parameter logic [6:0] I2C_SLAVE_ADDRESS = 7'h2a,
  parameter logic [7:0] CLOCK_SEL         = 8'h04
) (
  input  wire logic       clk,
  input  wire logic       async_reset_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            sclk_out,
  output logic            mosi_out,
  input  wire logic       miso_in,
  output logic [4:0]      select_n,
  output logic            intn
);
  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  logic [1:0] rst_pipe;
  logic       rst;
  logic       scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, miso_m, miso_s;

  always_ff @(posedge clk or posedge async_reset_in) begin
    if (async_reset_in) rst_pipe <= 2'h3;
    else                rst_pipe <= {rst_pipe[0], 1'b0};
  end
  assign rst = rst_pipe[1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      {miso_m, miso_s}      <= 2'h0;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
      {miso_m, miso_s}      <= {miso_in, miso_m};
    end
  end

  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;
  assign sda_out  = 1'b0;

  function automatic logic [7:0] bit_reverse(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) r[i] = v[7 - i];
    return r;
  endfunction : bit_reverse

  // ****************************************
  // Data buffer
  // ****************************************
  logic [7:0]        mem [BUF_DEPTH];
  logic              i2c_we, spi_we;
  logic [BUF_AW-1:0] i2c_waddr, spi_waddr;
  logic [7:0]        i2c_wdata, spi_wdata;

  always_ff @(posedge clk) begin
    if (spi_we)      mem[spi_waddr] <= spi_wdata;
    else if (i2c_we) mem[i2c_waddr] <= i2c_wdata;
  end

  // ****************************************
  // Two-wire slave
  // ****************************************
  i2sb_i2c_state_type st, next_st;
  logic [3:0] bcnt, next_bcnt;
  logic [7:0] sh, next_sh, tx_sh, next_tx_sh, cmd, next_cmd, cfg, next_cfg;
  logic [7:0] wr_cnt, next_wr_cnt;
  logic [6:0] rd_idx, next_rd_idx;
  logic       is_read, next_is_read, do_ack, next_do_ack, next_oe;
  logic       have_cmd, next_have_cmd, in_write, next_in_write, irq, next_irq;
  logic       spi_go, spi_done, busy;
  logic [7:0] rx_byte, rd_byte;

  assign rx_byte = {sh[6:0], sda_s};
  assign rd_byte = mem[rd_idx];

  always_comb begin
    next_st = st;  next_bcnt = bcnt;  next_sh = sh;  next_tx_sh = tx_sh;
    next_cmd = cmd;  next_cfg = cfg;  next_wr_cnt = wr_cnt;  next_rd_idx = rd_idx;
    next_is_read = is_read;  next_do_ack = do_ack;  next_oe = sda_oe;
    next_have_cmd = have_cmd;  next_in_write = in_write;  next_irq = irq;
    spi_go = 1'b0;  i2c_we = 1'b0;
    i2c_waddr = wr_cnt[BUF_AW-1:0];
    i2c_wdata = rx_byte;
    if (spi_done) next_irq = 1'b1;
    if (start_c) begin
      next_st = I2C_ADDR;  next_bcnt = 4'h0;  next_oe = 1'b0;  next_in_write = 1'b0;
    end else if (stop_c) begin
      next_st = I2C_IDLE;  next_oe = 1'b0;  next_in_write = 1'b0;
      if (in_write && have_cmd && cmd == CMD_WRITE && wr_cnt != 8'h00 && !busy)
        spi_go = 1'b1;
    end else begin
      case (st)
        I2C_ADDR, I2C_RX: if (scl_rise) begin
          next_sh   = rx_byte;
          next_bcnt = bcnt + 4'h1;
          if (bcnt == LAST_RX_BIT) begin
            next_st = I2C_ACK_WAIT;
            if (st == I2C_ADDR) begin
              next_do_ack  = (rx_byte[7:1] == I2C_SLAVE_ADDRESS) && !busy;
              next_is_read = rx_byte[0];
              next_rd_idx  = 7'h00;
              next_in_write = (rx_byte[7:1] == I2C_SLAVE_ADDRESS) && !busy && !rx_byte[0];
              next_have_cmd = 1'b0;
            end else if (!have_cmd) begin
              next_have_cmd = 1'b1;
              next_cmd      = rx_byte;
              next_wr_cnt   = 8'h00;
              next_do_ack   = 1'b1;
              if (rx_byte == CMD_CLRIRQ && !spi_done) next_irq = 1'b0;
            end else begin
              next_do_ack = 1'b1;
              case (cmd)
                CMD_CONFIG: next_cfg = rx_byte;
                CMD_WRITE: begin
                  if (wr_cnt == BUF_FULL_CNT) next_do_ack = 1'b0;
                  else begin
                    i2c_we      = 1'b1;
                    next_wr_cnt = wr_cnt + 8'h01;
                  end
                end
                default: ;
              endcase
            end
          end
        end
        I2C_ACK_WAIT: if (scl_fall) begin
          next_oe = do_ack;
          next_st = do_ack ? I2C_ACK : I2C_IDLE;
        end
        I2C_ACK: if (scl_fall) begin
          next_bcnt = 4'h0;
          if (is_read) begin
            next_tx_sh = rd_byte;
            next_oe    = ~rd_byte[7];
            next_st    = I2C_TX;
          end else begin
            next_oe = 1'b0;
            next_st = I2C_RX;
          end
        end
        I2C_TX: begin
          if (scl_rise) next_bcnt = bcnt + 4'h1;
          if (scl_fall) begin
            if (bcnt == BITS_PER_BYTE) begin
              next_oe = 1'b0;
              next_st = I2C_MACK;
            end else begin
              next_tx_sh = {tx_sh[6:0], 1'b0};
              next_oe    = ~tx_sh[6];
            end
          end
        end
        I2C_MACK: if (scl_rise) begin
          if (!sda_s) begin
            next_rd_idx = rd_idx + 7'h01;
            next_st     = I2C_TX_LOAD;
          end else next_st = I2C_IDLE;
        end
        I2C_TX_LOAD: if (scl_fall) begin
          next_tx_sh = rd_byte;
          next_oe    = ~rd_byte[7];
          next_bcnt  = 4'h0;
          next_st    = I2C_TX;
        end
        default: next_st = I2C_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= I2C_IDLE;  bcnt <= 4'h0;  sh <= 8'h00;  tx_sh <= 8'h00;
      cmd <= 8'h00;  cfg <= CFG_RESET;  wr_cnt <= 8'h00;  rd_idx <= 7'h00;
      is_read <= 1'b0;  do_ack <= 1'b0;  sda_oe <= 1'b0;
      have_cmd <= 1'b0;  in_write <= 1'b0;  irq <= 1'b0;
    end else begin
      st <= next_st;  bcnt <= next_bcnt;  sh <= next_sh;  tx_sh <= next_tx_sh;
      cmd <= next_cmd;  cfg <= next_cfg;  wr_cnt <= next_wr_cnt;  rd_idx <= next_rd_idx;
      is_read <= next_is_read;  do_ack <= next_do_ack;  sda_oe <= next_oe;
      have_cmd <= next_have_cmd;  in_write <= next_in_write;  irq <= next_irq;
    end
  end
  assign intn = ~irq;

  // ****************************************
  // Prefetch buffer toward the shifter
  // ****************************************
  logic [7:0] fifo_mem [2];
  logic       wp, rp, next_wp, next_rp, fifo_ready, fifo_valid, pf_valid, spi_pop;
  logic [1:0] fcnt, next_fcnt;
  logic [7:0] pf_idx, next_pf_idx, xfer_cnt;

  assign fifo_ready = (fcnt != FIFO_DEPTH);
  assign fifo_valid = (fcnt != 2'h0);
  assign pf_valid   = busy && (pf_idx < xfer_cnt);

  always_comb begin
    next_wp = wp;  next_rp = rp;  next_fcnt = fcnt;  next_pf_idx = pf_idx;
    if (spi_go) begin
      next_wp = 1'b0;  next_rp = 1'b0;  next_fcnt = 2'h0;  next_pf_idx = 8'h00;
    end else begin
      if (pf_valid && fifo_ready) begin
        next_wp     = ~wp;
        next_pf_idx = pf_idx + 8'h01;
      end
      if (spi_pop) next_rp = ~rp;
      next_fcnt = fcnt + {1'b0, pf_valid && fifo_ready} - {1'b0, spi_pop};
    end
  end

  always_ff @(posedge clk) begin
    if (pf_valid && fifo_ready && !spi_go) fifo_mem[wp] <= mem[pf_idx[BUF_AW-1:0]];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp <= 1'b0;  rp <= 1'b0;  fcnt <= 2'h0;  pf_idx <= 8'h00;
    end else begin
      wp <= next_wp;  rp <= next_rp;  fcnt <= next_fcnt;  pf_idx <= next_pf_idx;
    end
  end

  // ****************************************
  // SPI master
  // ****************************************
  i2sb_spi_state_type sst, next_sst;
  logic [7:0] div, next_div, stx, next_stx, srx, next_srx, sidx, next_sidx;
  logic [7:0] next_xfer_cnt;
  logic [3:0] edge_n, next_edge_n;
  logic       next_sclk, next_mosi, cpha, lsb_first, lead, do_shift, do_sample;
  logic [4:0] next_sel;
  logic [7:0] rx_final;

  assign busy      = (sst != SPI_IDLE);
  assign cpha      = cfg[CFG_CPHA_BIT];
  assign lsb_first = cfg[CFG_ORDER_BIT];
  assign lead      = ~edge_n[0];
  assign do_shift  = cpha ? (lead && edge_n != 4'h0) : !lead;
  assign do_sample = cpha ? !lead : lead;
  assign rx_final  = do_sample ? {srx[6:0], miso_s} : srx;

  always_comb begin
    next_sst = sst;  next_div = div;  next_stx = stx;  next_srx = srx;
    next_sidx = sidx;  next_xfer_cnt = xfer_cnt;  next_edge_n = edge_n;
    next_sclk = sclk_out;  spi_pop = 1'b0;  spi_done = 1'b0;
    spi_we = 1'b0;  spi_waddr = sidx[BUF_AW-1:0];
    spi_wdata = lsb_first ? bit_reverse(rx_final) : rx_final;
    case (sst)
      SPI_IDLE: begin
        next_sclk = cfg[CFG_CPOL_BIT];
        if (spi_go) begin
          next_sidx     = 8'h00;
          next_xfer_cnt = wr_cnt;
          next_sst      = SPI_LOAD;
        end
      end
      SPI_LOAD: if (fifo_valid) begin
        spi_pop     = 1'b1;
        next_stx    = lsb_first ? bit_reverse(fifo_mem[rp]) : fifo_mem[rp];
        next_edge_n = 4'h0;
        next_div    = 8'h00;
        next_sst    = SPI_SHIFT;
      end
      SPI_SHIFT: begin
        if (div == CLOCK_SEL) begin
          next_div    = 8'h00;
          next_sclk   = ~sclk_out;
          next_edge_n = edge_n + 4'h1;
          if (do_sample) next_srx = {srx[6:0], miso_s};
          if (do_shift)  next_stx = {stx[6:0], 1'b0};
          if (edge_n == LAST_EDGE) begin
            spi_we    = 1'b1;
            next_sidx = sidx + 8'h01;
            if (sidx + 8'h01 == xfer_cnt) begin
              spi_done = 1'b1;
              next_sst = SPI_IDLE;
            end else next_sst = SPI_LOAD;
          end
        end else next_div = div + 8'h01;
      end
      default: next_sst = SPI_IDLE;
    endcase
    next_mosi = next_stx[7];
    // Selects held through the cycle of the last clock edge
    next_sel  = cfg[CFG_SEL_MSB:CFG_SEL_LSB];
    if (next_sst == SPI_IDLE && sst == SPI_IDLE) next_sel = SEL_IDLE;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sst <= SPI_IDLE;  div <= 8'h00;  stx <= 8'h00;  srx <= 8'h00;  sidx <= 8'h00;
      xfer_cnt <= 8'h00;  edge_n <= 4'h0;  sclk_out <= 1'b0;  mosi_out <= 1'b0;
      select_n <= SEL_IDLE;
    end else begin
      sst <= next_sst;  div <= next_div;  stx <= next_stx;  srx <= next_srx;
      sidx <= next_sidx;  xfer_cnt <= next_xfer_cnt;  edge_n <= next_edge_n;
      sclk_out <= next_sclk;  mosi_out <= next_mosi;  select_n <= next_sel;
    end
  end
endmodule : i2sb_bridge

// ==== i2sb_bridge_sva.sv ====
// Purpose: Pin assertions of the bridge
// Assumes: Bound to i2sb_bridge
// Notes:   One clock domain
`timescale 1ns/100ps
module i2sb_bridge_chk
  import i2sb_pkg::*;
#(
  parameter logic [7:0] CLOCK_SEL = 8'h04
) (
  input wire logic       clk,
  input wire logic       async_reset_in,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       sclk_out,
  input wire logic [4:0] select_n,
  input wire logic       intn
);
  default clocking @(posedge clk); endclocking
  default disable iff (async_reset_in);
  logic       sclk_d;
  logic [7:0] half_cnt;
  logic [7:0] next_half_cnt;
  wire  logic busy = select_n != SEL_IDLE;
  // Cycles since the last SPI clock change
  always_comb begin
    next_half_cnt = half_cnt;
    if (sclk_out != sclk_d)
      next_half_cnt = 8'h00;
    else if (half_cnt != 8'hff)
      next_half_cnt = half_cnt + 8'h01;
  end
  always_ff @(posedge clk or posedge async_reset_in) begin
    if (async_reset_in) begin
      sclk_d   <= 1'b0;
      half_cnt <= 8'hff;
    end else begin
      sclk_d   <= sclk_out;
      half_cnt <= next_half_cnt;
    end
  end
  sequence s_xfer_end;
    busy ##1 !busy;
  endsequence
  sequence s_irq_fall;
    intn ##1 !intn;
  endsequence
  chk_sda_drive_low: assert property (sda_oe |-> !sda_out)
    else $error("sda driven high");
  chk_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("sda moved while scl high");
  chk_busy_no_ack: assert property (busy |-> !sda_oe)
    else $error("bus answered during transfer");
  chk_sel_steady: assert property (busy && $past(busy) |-> $stable(select_n))
    else $error("select moved in transfer");
  chk_sclk_half: assert property (busy && $changed(sclk_out) |-> half_cnt >= CLOCK_SEL)
    else $error("sclk half period short");
  chk_done_irq: assert property (s_xfer_end |-> !intn)
    else $error("no interrupt at end");
  chk_irq_cause: assert property (s_irq_fall |-> $past(busy))
    else $error("interrupt without transfer");
  chk_irq_clear: assert property ($rose(intn) |-> scl_in && !busy)
    else $error("interrupt cleared off the bus");
  chk_reset_idle: assert property (disable iff (1'b0)
    async_reset_in |=> select_n == SEL_IDLE && intn && !sda_oe)
    else $error("outputs not idle in reset");
endmodule : i2sb_bridge_chk

bind i2sb_bridge i2sb_bridge_chk #(.CLOCK_SEL(CLOCK_SEL)) u_chk (
  .clk(clk), .async_reset_in(async_reset_in), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .sclk_out(sclk_out), .select_n(select_n), .intn(intn));

// ==== i2sb_spi_slave.sv ====
// Purpose: SPI slave model facing the bridge
// Assumes: Mode and bit order from the bench
// Notes:   Logs bytes taken and bytes returned
`timescale 1ns/100ps
module i2sb_spi_slave (
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsb,
  input  wire logic [4:0] select_n,
  output logic            miso
);
  logic [7:0] tx;
  logic [7:0] rx;
  logic       q = 1'b0;
  int         bitn;
  int         nbytes;
  logic [7:0] got [128];
  logic [7:0] sent [129];
  wire  logic sel = ~&select_n;
  function automatic logic pick(input logic [7:0] b, input int n);
    return lsb ? b[n] : b[7-n];
  endfunction : pick
  // Released line shows the inverse level
  assign miso = sel ? q : ~q;
  always @(posedge sel) begin
    bitn = 0;
    nbytes = 0;
    tx = 8'h5b;
    sent[0] = tx;
    q = pick(tx, 0);
  end
  always @(sclk) begin
    if (sel && (sclk ^ cpol ^ cpha)) begin
      rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
      bitn++;
    end else if (sel) begin
      q = pick(tx, bitn);
    end
    if (bitn == 8) begin
      got[nbytes] = rx;
      nbytes++;
      bitn = 0;
      tx = 8'h5b + 8'(nbytes * 37);
      sent[nbytes] = tx;
    end
  end
endmodule : i2sb_spi_slave

// ==== tb_i2c_to_spi_bridge.sv ====
// Purpose: Self-checking bench of the bridge
// Assumes: Bus quarter bit of six clocks, divider two
// Notes:   Random data from a fixed seed
`timescale 1ns/100ps
module tb_i2c_to_spi_bridge
  import i2sb_pkg::*;
;
  localparam logic [6:0] ADDR = 7'h2a;
  logic       clk, async_reset_in, scl, sda_d;
  logic       sda_out, sda_oe, sclk_out, mosi_out, miso, intn;
  logic [4:0] select_n, sel_seen;
  logic [7:0] cfg;
  logic [7:0] wr [130];
  wire  logic sda = sda_oe ? sda_out : sda_d;
  int         err_count, num_checks;
  i2sb_bridge #(.I2C_SLAVE_ADDRESS(ADDR), .CLOCK_SEL(8'h02)) DUT (
    .clk(clk), .async_reset_in(async_reset_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .sclk_out(sclk_out), .mosi_out(mosi_out),
    .miso_in(miso), .select_n(select_n), .intn(intn));
  i2sb_spi_slave u_slave (.sclk(sclk_out), .mosi(mosi_out), .cpol(cfg[0]),
    .cpha(cfg[1]), .lsb(cfg[2]), .select_n(select_n), .miso(miso));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (select_n != SEL_IDLE) sel_seen <= select_n;
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic qtr();
    repeat (6) @(posedge clk);
  endtask : qtr
  task automatic bus_bit(input logic b, output logic r);
    sda_d <= b;
    qtr();
    scl <= 1'b1;
    qtr();
    r = sda;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask : bus_bit
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bus_bit(b[i], r);
    bus_bit(1'b1, r);
    ack = ~r;
  endtask : send
  task automatic recv(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bus_bit(1'b1, b[i]);
    bus_bit(~more, r);
  endtask : recv
  task automatic bus_start();
    sda_d <= 1'b1;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_d <= 1'b0;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask : bus_start
  task automatic bus_stop();
    sda_d <= 1'b0;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_d <= 1'b1;
    qtr();
  endtask : bus_stop
  task automatic write_cmd(input logic [6:0] a, input logic [7:0] cmd, input int n,
                           output logic ack);
    logic k;
    bus_start();
    send({a, 1'b0}, ack);
    if (ack) send(cmd, k);
    for (int i = 0; i < n && ack; i++) send(wr[i], k);
    bus_stop();
  endtask : write_cmd
  task automatic read_back(input int n);
    logic       ack;
    logic [7:0] b;
    bus_start();
    send({ADDR, 1'b1}, ack);
    check("read ack", 8'(ack), 8'h01);
    for (int i = 0; i < n; i++) begin
      recv(i < n - 1, b);
      check("read byte", b, u_slave.sent[i % 128]);
    end
    bus_stop();
  endtask : read_back
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (95000) @(posedge clk);
    err_count++;
    complete_run();
  end
  initial begin
    logic ack;
    int   n;
    scl = 1'b1;
    sda_d = 1'b1;
    async_reset_in = 1'b1;
    cfg = CFG_RESET;
    err_count = 0;
    num_checks = 0;
    void'($urandom(93));
    repeat (16) @(posedge clk);
    async_reset_in <= 1'b0;
    check("reset sel", 8'(select_n), 8'(SEL_IDLE));
    check("reset irq", 8'(intn), 8'h01);
    repeat (4) @(posedge clk);
    for (int t = 0; t < 4; t++) begin
      wr[0] = {5'($urandom) & ~(5'h01 << t), 3'(t * 3)};
      cfg <= wr[0];
      write_cmd(ADDR, CMD_CONFIG, 1, ack);
      check("addr ack", 8'(ack), 8'h01);
      n = (t == 0) ? 1 : (t == 1) ? 128 : 2 + $urandom % 5;
      for (int i = 0; i < n + 2; i++) wr[i] = 8'($urandom);
      write_cmd(ADDR, CMD_WRITE, n, ack);
      if (t == 1) begin
        bus_start();
        send({ADDR, 1'b1}, ack);
        bus_stop();
        check("busy nack", 8'(ack), 8'h00);
      end
      for (int k = 0; k < 50000 && intn !== 1'b0; k++) @(posedge clk);
      check("irq done", 8'(intn), 8'h00);
      check("select", 8'(sel_seen), 8'(cfg[7:3]));
      check("spi count", 8'(u_slave.nbytes), 8'(n));
      for (int i = 0; i < n; i++) check("mosi byte", u_slave.got[i], wr[i]);
      write_cmd(ADDR, (t == 0) ? 8'h00 : 8'h03 + 8'(1 + $urandom % 252), 2, ack);
      write_cmd(ADDR ^ 7'(1 + $urandom % 127), CMD_CLRIRQ, 0, ack);
      check("foreign addr", 8'(ack), 8'h00);
      check("irq kept", 8'(intn), 8'h00);
      read_back((t == 1) ? 130 : n);
      write_cmd(ADDR, CMD_CLRIRQ, 0, ack);
      check("irq clear", 8'(intn), 8'h01);
      $display("Test %0d done", t);
    end
    complete_run();
  end
endmodule : tb_i2c_to_spi_bridge
